// *** design/fpoc_front.sv ***
// Operand front end of a floating-point unit: escape decode, stack-relative register mapping,
// classification of extended-precision operands, exception flags and result packing.
// Assumes the core supplies instruction bytes, memory operands and register contents on clk_sys_i.
// Operation
// - Exponent all ones, integer bit 0: pseudo-infinity or quiet/signaling pseudo-NaN.
// - Middle exponent with integer 0 is unnormal; zero exponent with integer 1 pseudo-denormal.
// - Operand split as sign, 15-bit exponent, integer bit, 63-bit fraction.
// - Pseudo-NaN, pseudo-infinity or unnormal source raises invalid-operation instead.
// - Packed results never pseudo-denormal: integer bit cleared when exponent zero.
// - Pseudo-denormal source accepted as denormal and raises the denormal exception.
// - First opcode byte D8 to DF inclusive marks the floating-point opcode group.
// - Operands come from the register stack or from memory.
// - No immediate operand path exists for floating-point instructions.
// - Register operands addressed relative to current stack top.
// - With no explicit register, the stack head register is the operand.
// - Instructions sorted into six dispatch groups.
// - Pop marks the head empty and increments the stack-top pointer by one.
`include "fpoc_map.svh"
`timescale 1ns/100ps
module fpoc_front #(
  parameter int NREGS = `FPOC_NREGS
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       clk_en_i,
  input  wire logic                       insn_valid_i,
  input  wire logic [7:0]                 opcode_byte_i,
  input  wire logic [7:0]                 modrm_byte_i,
  input  wire logic [`FPOC_EXT_W-1:0]     mem_operand_i,
  input  wire logic [`FPOC_EXT_W-1:0]     stack_head_register_i,
  input  wire logic [`FPOC_EXT_W-1:0]     stack_relative_register_i,
  input  wire logic                       pop_i,
  input  wire logic                       res_valid_i,
  input  wire logic [`FPOC_EXT_W-1:0]     res_raw_i,
  output logic                            fp_opcode_group_o,
  output fpoc_pkg::fpoc_group_t           group_o,
  output fpoc_pkg::fpoc_src_t             src_kind_o,
  output logic [`FPOC_IDX_W-1:0]          head_phys_o,
  output logic [`FPOC_IDX_W-1:0]          rel_phys_o,
  output logic [`FPOC_IDX_W-1:0]          top_o,
  output logic [NREGS-1:0]                empty_o,
  output fpoc_pkg::fpoc_class_t           class_a_o,
  output fpoc_pkg::fpoc_class_t           class_b_o,
  output logic                            dec_valid_o,
  output logic                            invalid_op_o,
  output logic                            denormal_o,
  output logic                            res_valid_o,
  output logic [`FPOC_EXT_W-1:0]          res_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  function automatic fpoc_pkg::fpoc_class_t classify(input logic [`FPOC_EXT_W-1:0] v);
    logic [`FPOC_EXP_W-1:0]  e;
    logic                    ib;
    logic [`FPOC_FRAC_W-1:0] f;
    e  = v[`FPOC_EXP_HI:`FPOC_EXP_LO];
    ib = v[`FPOC_INT_BIT];
    f  = v[`FPOC_FRAC_HI:0];
    if (e == `FPOC_EXP_ONES) begin
      if (!ib) begin
        if (f == '0)                 classify = fpoc_pkg::FPOC_CLS_PSEUDO_INF;
        else if (f[`FPOC_FRAC_HI])   classify = fpoc_pkg::FPOC_CLS_PSEUDO_QNAN;
        else                         classify = fpoc_pkg::FPOC_CLS_PSEUDO_SNAN;
      end else if (f == '0)          classify = fpoc_pkg::FPOC_CLS_INF;
      else if (f[`FPOC_FRAC_HI])     classify = fpoc_pkg::FPOC_CLS_QNAN;
      else                           classify = fpoc_pkg::FPOC_CLS_SNAN;
    end else if (e == `FPOC_EXP_ZERO) begin
      if (ib)                        classify = fpoc_pkg::FPOC_CLS_PSEUDO_DENORM;
      else if (f == '0)              classify = fpoc_pkg::FPOC_CLS_ZERO;
      else                           classify = fpoc_pkg::FPOC_CLS_DENORMAL;
    end else if (!ib)                classify = fpoc_pkg::FPOC_CLS_UNNORMAL;
    else                             classify = fpoc_pkg::FPOC_CLS_NORMAL;
  endfunction

  function automatic logic is_unsupported(input fpoc_pkg::fpoc_class_t c);
    is_unsupported = (c == fpoc_pkg::FPOC_CLS_PSEUDO_QNAN) || (c == fpoc_pkg::FPOC_CLS_PSEUDO_SNAN) ||
                     (c == fpoc_pkg::FPOC_CLS_PSEUDO_INF) || (c == fpoc_pkg::FPOC_CLS_UNNORMAL);
  endfunction

  function automatic logic is_denorm(input fpoc_pkg::fpoc_class_t c);
    is_denorm = (c == fpoc_pkg::FPOC_CLS_DENORMAL) || (c == fpoc_pkg::FPOC_CLS_PSEUDO_DENORM);
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic                  opg_hit;
  logic                  reg_form;
  logic [2:0]            sub_op;
  logic [2:0]            rm_idx;
  fpoc_pkg::fpoc_group_t grp;
  logic                  two_src;

  assign opg_hit  = (opcode_byte_i & `FPOC_OPG_MASK) == `FPOC_OPG_LO;
  assign reg_form = &modrm_byte_i[7:6];
  assign sub_op   = modrm_byte_i[5:3];
  assign rm_idx   = modrm_byte_i[2:0];

  // Coarse split only; full opcode tables live in the execution stage
  always_comb begin
    two_src = 1'b0;
    grp     = fpoc_pkg::FPOC_GRP_ARITH;
    if (opcode_byte_i[0] && !reg_form && sub_op >= 3'h4) begin
      grp = fpoc_pkg::FPOC_GRP_CONTROL;
    end else if (opcode_byte_i[0] && reg_form && sub_op == 3'h5) begin
      grp = fpoc_pkg::FPOC_GRP_CONST;
    end else if (opcode_byte_i[0] && reg_form && sub_op >= 3'h6) begin
      grp = fpoc_pkg::FPOC_GRP_TRANSC;
    end else if (opcode_byte_i[0] || (opcode_byte_i[2] && opcode_byte_i[1])) begin
      grp = fpoc_pkg::FPOC_GRP_TRANSFER;
    end else if (sub_op == 3'h2 || sub_op == 3'h3) begin
      grp     = fpoc_pkg::FPOC_GRP_COMPARE;
      two_src = 1'b1;
    end else begin
      two_src = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register stack pointer and tags
  // ----------------------------------------------------------------
  logic [`FPOC_IDX_W-1:0] top_reg;
  logic [NREGS-1:0]       empty_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      top_reg <= '0;
    end else if (clk_en_i && pop_i) begin
      top_reg <= top_reg + `FPOC_POP_STEP;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      empty_reg <= '1;
    end else if (clk_en_i && pop_i) begin
      empty_reg[top_reg] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Operand sourcing and checks
  // ----------------------------------------------------------------
  logic [`FPOC_EXT_W-1:0] op_a;
  logic [`FPOC_EXT_W-1:0] op_b;
  fpoc_pkg::fpoc_class_t  cls_a;
  fpoc_pkg::fpoc_class_t  cls_b;
  logic                   inv_hit;
  logic                   den_hit;

  // No immediate field is ever extracted: only stack or memory feed operands
  assign op_a    = stack_head_register_i;
  assign op_b    = reg_form ? stack_relative_register_i : mem_operand_i;
  assign cls_a   = classify(op_a);
  assign cls_b   = classify(op_b);
  assign inv_hit = is_unsupported(cls_a) || (two_src && is_unsupported(cls_b));
  // Invalid takes precedence, so the value is never computed on
  assign den_hit = !inv_hit && (is_denorm(cls_a) || (two_src && is_denorm(cls_b)));

  always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fp_opcode_group_o <= 1'b0;
      dec_valid_o       <= 1'b0;
      group_o           <= fpoc_pkg::FPOC_GRP_ARITH;
      src_kind_o        <= fpoc_pkg::FPOC_SRC_NONE;
      head_phys_o       <= '0;
      rel_phys_o        <= '0;
      class_a_o         <= fpoc_pkg::FPOC_CLS_ZERO;
      class_b_o         <= fpoc_pkg::FPOC_CLS_ZERO;
      invalid_op_o      <= 1'b0;
      denormal_o        <= 1'b0;
    end else if (clk_en_i) begin
      fp_opcode_group_o <= opg_hit;
      dec_valid_o       <= insn_valid_i && opg_hit;
      group_o           <= grp;
      src_kind_o        <= reg_form ? fpoc_pkg::FPOC_SRC_STACK : fpoc_pkg::FPOC_SRC_MEMORY;
      head_phys_o       <= top_reg;
      rel_phys_o        <= top_reg + rm_idx;
      class_a_o         <= cls_a;
      class_b_o         <= cls_b;
      invalid_op_o      <= insn_valid_i && opg_hit && inv_hit;
      denormal_o        <= insn_valid_i && opg_hit && den_hit;
    end
  end

  // ----------------------------------------------------------------
  // Result packing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      res_valid_o <= 1'b0;
      res_o       <= '0;
    end else if (clk_en_i) begin
      res_valid_o <= res_valid_i;
      res_o       <= res_raw_i;
      if (res_raw_i[`FPOC_EXP_HI:`FPOC_EXP_LO] == `FPOC_EXP_ZERO) begin
        res_o[`FPOC_INT_BIT] <= 1'b0;
      end
    end
  end

  assign top_o   = top_reg;
  assign empty_o = empty_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_reg);

  sequence pop_seen_s;
    clk_en_i && pop_i;
  endsequence

  pack_no_pdenorm_a: assert property (
    res_o[`FPOC_EXP_HI:`FPOC_EXP_LO] != `FPOC_EXP_ZERO || !res_o[`FPOC_INT_BIT])
    else $error("Result packed as pseudo-denormal");
  pop_top_step_a: assert property (pop_seen_s |=> top_reg == $past(top_reg) + `FPOC_POP_STEP)
    else $error("Pop did not advance stack top by one");
  pop_marks_empty_a: assert property (pop_seen_s |=> empty_reg[$past(top_reg)])
    else $error("Pop left head register tagged full");
  top_hold_a: assert property (!(clk_en_i && pop_i) |=> $stable(top_reg))
    else $error("Stack top moved without a taken pop");
  rel_map_a: assert property (clk_en_i |=> rel_phys_o == $past(top_reg) + $past(rm_idx))
    else $error("Stack-relative mapping wrong");
  group_range_a: assert property (clk_en_i |=> fp_opcode_group_o ==
    ($past(opcode_byte_i) >= `FPOC_OPG_LO && $past(opcode_byte_i) <= `FPOC_OPG_HI))
    else $error("Opcode group decode wrong");
  unsup_invalid_a: assert property (clk_en_i && insn_valid_i && opg_hit && is_unsupported(cls_a)
    |=> invalid_op_o && !denormal_o)
    else $error("Unsupported operand did not raise invalid");
  pdenorm_flag_a: assert property (clk_en_i && insn_valid_i && opg_hit && !inv_hit &&
    cls_a == fpoc_pkg::FPOC_CLS_PSEUDO_DENORM |=> denormal_o)
    else $error("Pseudo-denormal missed denormal flag");
  pinf_class_a: assert property (clk_en_i && stack_head_register_i[`FPOC_EXP_HI:`FPOC_EXP_LO] == `FPOC_EXP_ONES
    && !stack_head_register_i[`FPOC_INT_BIT] && stack_head_register_i[`FPOC_FRAC_HI:0] == '0
    |=> class_a_o == fpoc_pkg::FPOC_CLS_PSEUDO_INF)
    else $error("Pseudo-infinity misclassified");
  unnormal_class_a: assert property (clk_en_i && !stack_head_register_i[`FPOC_INT_BIT]
    && stack_head_register_i[`FPOC_EXP_HI:`FPOC_EXP_LO] != `FPOC_EXP_ZERO
    && stack_head_register_i[`FPOC_EXP_HI:`FPOC_EXP_LO] != `FPOC_EXP_ONES
    |=> class_a_o == fpoc_pkg::FPOC_CLS_UNNORMAL)
    else $error("Unnormal misclassified");

endmodule

// *** design/fpoc_map.svh ***
// Constants for the floating-point operand front end: field layout, opcode range, stack geometry.
// Assumes inclusion by bare name from the package and the design module.
`ifndef FPOC_MAP_SVH
`define FPOC_MAP_SVH
`define FPOC_EXT_W       80
`define FPOC_SIGN_BIT    79
`define FPOC_EXP_HI      78
`define FPOC_EXP_LO      64
`define FPOC_EXP_W       15
`define FPOC_INT_BIT     63
`define FPOC_FRAC_HI     62
`define FPOC_FRAC_W      63
`define FPOC_EXP_ONES    15'h7fff
`define FPOC_EXP_ZERO    15'h0000
`define FPOC_OPG_LO      8'hd8
`define FPOC_OPG_HI      8'hdf
`define FPOC_OPG_MASK    8'hf8
`define FPOC_NREGS       8
`define FPOC_IDX_W       3
`define FPOC_POP_STEP    3'h1
`endif

// *** design/fpoc_pkg.sv ***
// Types shared by the floating-point operand front end.
// Assumes the constant header is on the include path.
`include "fpoc_map.svh"
package fpoc_pkg;
  typedef enum logic [3:0] {
    FPOC_CLS_NORMAL, FPOC_CLS_ZERO, FPOC_CLS_DENORMAL, FPOC_CLS_INF, FPOC_CLS_QNAN, FPOC_CLS_SNAN,
    FPOC_CLS_PSEUDO_QNAN, FPOC_CLS_PSEUDO_SNAN, FPOC_CLS_PSEUDO_INF, FPOC_CLS_UNNORMAL,
    FPOC_CLS_PSEUDO_DENORM
  } fpoc_class_t;
  typedef enum logic [2:0] {
    FPOC_GRP_TRANSFER, FPOC_GRP_ARITH, FPOC_GRP_COMPARE, FPOC_GRP_TRANSC, FPOC_GRP_CONST, FPOC_GRP_CONTROL
  } fpoc_group_t;
  typedef enum logic [1:0] {
    FPOC_SRC_NONE, FPOC_SRC_STACK, FPOC_SRC_MEMORY
  } fpoc_src_t;
endpackage

// *** test/tb_top.sv ***
// Self-checking bench for the floating-point operand front end.
// Assumes the package and the front-end module are compiled first; clock 250 MHz.
`timescale 1ns/100ps
module tb_top;
  // ------------------------------------------------------------
  // Stimulus signals
  // ------------------------------------------------------------
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic        clk_en_i  = 1'b1;
  logic        insn_valid_i = 1'b0, pop_i = 1'b0, res_valid_i = 1'b0;
  logic [7:0]  opcode_byte_i = 8'h00, modrm_byte_i = 8'h00;
  logic [79:0] mem_operand_i = 80'h0, stack_head_register_i = 80'h0, stack_relative_register_i = 80'h0;
  logic [79:0] res_raw_i = 80'h0;
  logic        fp_opcode_group_o, dec_valid_o, invalid_op_o, denormal_o, res_valid_o;
  fpoc_pkg::fpoc_group_t group_o;
  fpoc_pkg::fpoc_src_t   src_kind_o;
  fpoc_pkg::fpoc_class_t class_a_o, class_b_o;
  logic [2:0]  head_phys_o, rel_phys_o, top_o;
  logic [7:0]  empty_o;
  logic [79:0] res_o;
  int          failures = 0, check_count = 0;
  logic [2:0]  top_exp = 3'h0;
  localparam logic [79:0] NORM = 80'h3fff8000000000000000, PINF = 80'h7fff0000000000000000;
  localparam logic [79:0] PQNAN = 80'h7fff4000000000000000, PSNAN = 80'h7fff0000000000000001;
  localparam logic [79:0] UNORM = 80'h40001234000000000000, PDEN = 80'h00008000000000000001;
  localparam logic [79:0] DENRM = 80'h00000000000000000001;

  always #2 clk_sys_i = ~clk_sys_i;

  fpoc_front u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .insn_valid_i(insn_valid_i),
    .opcode_byte_i(opcode_byte_i), .modrm_byte_i(modrm_byte_i), .mem_operand_i(mem_operand_i),
    .stack_head_register_i(stack_head_register_i), .stack_relative_register_i(stack_relative_register_i),
    .pop_i(pop_i), .res_valid_i(res_valid_i), .res_raw_i(res_raw_i), .fp_opcode_group_o(fp_opcode_group_o),
    .group_o(group_o), .src_kind_o(src_kind_o), .head_phys_o(head_phys_o), .rel_phys_o(rel_phys_o),
    .top_o(top_o), .empty_o(empty_o), .class_a_o(class_a_o), .class_b_o(class_b_o), .dec_valid_o(dec_valid_o),
    .invalid_op_o(invalid_op_o), .denormal_o(denormal_o), .res_valid_o(res_valid_o), .res_o(res_o));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Instruction stays valid afterwards; repeating it is harmless and keeps back-to-back spacing
  task automatic issue(input logic [7:0] op, input logic [7:0] mrm, input logic [79:0] a, b, m);
    @(posedge clk_sys_i);
    insn_valid_i <= 1'b1;
    opcode_byte_i <= op;
    modrm_byte_i <= mrm;
    stack_head_register_i <= a;
    stack_relative_register_i <= b;
    mem_operand_i <= m;
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic results();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic cls(input logic [79:0] a, input fpoc_pkg::fpoc_class_t c, input logic inv, den);
    issue(8'hd8, 8'hc1, a, NORM, NORM);
    chk(80'(class_a_o), 80'(c));
    chk(80'(invalid_op_o), 80'(inv));
    chk(80'(denormal_o), 80'(den));
  endtask

  task automatic test_classes();
    cls(PINF, fpoc_pkg::FPOC_CLS_PSEUDO_INF, 1'b1, 1'b0);
    cls(PQNAN, fpoc_pkg::FPOC_CLS_PSEUDO_QNAN, 1'b1, 1'b0);
    cls(PSNAN, fpoc_pkg::FPOC_CLS_PSEUDO_SNAN, 1'b1, 1'b0);
    cls(UNORM, fpoc_pkg::FPOC_CLS_UNNORMAL, 1'b1, 1'b0);
    cls(PDEN, fpoc_pkg::FPOC_CLS_PSEUDO_DENORM, 1'b0, 1'b1);
    cls(DENRM, fpoc_pkg::FPOC_CLS_DENORMAL, 1'b0, 1'b1);
    cls(NORM, fpoc_pkg::FPOC_CLS_NORMAL, 1'b0, 1'b0);
    issue(8'hd8, 8'hc1, NORM, UNORM, NORM);
    chk(80'(class_b_o), 80'(fpoc_pkg::FPOC_CLS_UNNORMAL));
    chk(80'(invalid_op_o), 80'h1);
    chk(80'(src_kind_o), 80'(fpoc_pkg::FPOC_SRC_STACK));
    chk(80'(group_o), 80'(fpoc_pkg::FPOC_GRP_ARITH));
    issue(8'hd8, 8'h05, NORM, UNORM, PDEN);
    chk(80'(src_kind_o), 80'(fpoc_pkg::FPOC_SRC_MEMORY));
    chk(80'(class_b_o), 80'(fpoc_pkg::FPOC_CLS_PSEUDO_DENORM));
    chk(80'(denormal_o), 80'h1);
    issue(8'hd8, 8'hd1, NORM, NORM, NORM);
    chk(80'(group_o), 80'(fpoc_pkg::FPOC_GRP_COMPARE));
    issue(8'hd9, 8'h00, NORM, NORM, NORM);
    chk(80'(group_o), 80'(fpoc_pkg::FPOC_GRP_TRANSFER));
    issue(8'hd9, 8'h20, NORM, NORM, NORM);
    chk(80'(group_o), 80'(fpoc_pkg::FPOC_GRP_CONTROL));
    issue(8'hd9, 8'he8, NORM, NORM, NORM);
    chk(80'(group_o), 80'(fpoc_pkg::FPOC_GRP_CONST));
    issue(8'hd9, 8'hf0, NORM, NORM, NORM);
    chk(80'(group_o), 80'(fpoc_pkg::FPOC_GRP_TRANSC));
    $display("test classes done");
  endtask

  task automatic test_escape();
    logic exp;
    for (int op = 'hd0; op <= 'he7; op++) begin
      issue(8'(op), 8'hc1, PINF, NORM, NORM);
      exp = (op >= 'hd8) && (op <= 'hdf);
      chk(80'(dec_valid_o), 80'(exp));
      chk(80'(fp_opcode_group_o), 80'(exp));
      chk(80'(invalid_op_o), 80'(exp));
    end
    $display("test escape done");
  endtask

  // Pop taken in the same cycle as a decode: decode must still see the old top
  task automatic test_stack();
    for (int k = 0; k < 9; k++) begin
      @(posedge clk_sys_i);
      opcode_byte_i <= 8'hd8;
      modrm_byte_i <= 8'hc0 | 8'(k % 8);
      stack_head_register_i <= NORM;
      pop_i <= 1'b1;
      @(posedge clk_sys_i);
      pop_i <= 1'b0;
      #1;
      chk(80'(head_phys_o), 80'(top_exp));
      chk(80'(rel_phys_o), 80'(3'(top_exp + 3'(k))));
      top_exp = top_exp + 3'h1;
      chk(80'(top_o), 80'(top_exp));
      chk(80'(empty_o), 80'hff);
    end
    $display("test stack done");
  endtask

  // A low enable must freeze decode results and ignore a pending pop
  task automatic test_enable();
    issue(8'hd8, 8'hc1, PINF, NORM, NORM);
    @(posedge clk_sys_i);
    clk_en_i <= 1'b0;
    insn_valid_i <= 1'b0;
    stack_head_register_i <= NORM;
    pop_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk(80'(class_a_o), 80'(fpoc_pkg::FPOC_CLS_PSEUDO_INF));
    chk(80'(invalid_op_o), 80'h1);
    chk(80'(dec_valid_o), 80'h1);
    chk(80'(top_o), 80'(top_exp));
    @(posedge clk_sys_i);
    clk_en_i <= 1'b1;
    pop_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk(80'(dec_valid_o), 80'h0);
    chk(80'(invalid_op_o), 80'h0);
    chk(80'(class_a_o), 80'(fpoc_pkg::FPOC_CLS_NORMAL));
    chk(80'(top_o), 80'(top_exp));
    $display("test enable done");
  endtask

  task automatic test_reset();
    repeat (16) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk(80'(top_o), 80'h0);
    chk(80'(empty_o), 80'hff);
    chk(80'(dec_valid_o), 80'h0);
    $display("test reset done");
  endtask

  task automatic pack(input logic [79:0] raw, input logic [79:0] exp);
    @(posedge clk_sys_i);
    res_valid_i <= 1'b1;
    res_raw_i <= raw;
    @(posedge clk_sys_i);
    res_valid_i <= 1'b0;
    #1;
    chk(80'(res_valid_o), 80'h1);
    chk(res_o, exp);
  endtask

  task automatic test_pack();
    pack(PDEN, 80'h00000000000000000001);
    pack(80'h80008000000000000000, 80'h80000000000000000000);
    pack(NORM, NORM);
    @(posedge clk_sys_i);
    #1;
    chk(80'(res_valid_o), 80'h0);
    $display("test pack done");
  endtask

  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  initial begin
    test_reset();
    test_classes();
    test_escape();
    test_stack();
    test_enable();
    test_pack();
    results();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    results();
  end
endmodule
